// ---- common/cfds_defines.svh ----
// Constants for the crosspoint field-delay scheduler
`ifndef CFDS_DEFINES_SVH
`define CFDS_DEFINES_SVH

// Smallest delay in fields, fixed for each router variant
`define CFDS_MIN_DELAY 8'h01
// Largest delay in fields
`define CFDS_MAX_DELAY 8'h3C
// Delay used until the stored value is reloaded
`define CFDS_DELAY_RST 8'h01
// Extra field added to the target
`define CFDS_FIELD_ADD 8'h01
// Number of buffered crosspoints
`define CFDS_DEPTH 16
// Index width of the buffer
`define CFDS_IDX_W 4

`endif

// ---- common/cfds_pkg.sv ----
// Types for the crosspoint field-delay scheduler
package cfds_pkg;

  // One crosspoint connection
  typedef struct packed {
    logic [7:0] out_num; // Output number
    logic [7:0] in_num;  // Input number
    logic [3:0] level;   // Level, zero for all levels
    logic [1:0] port;    // Control port that sent it
  } cfds_xpt_t;

  // Field counter and tag value
  typedef logic [7:0] cfds_field_t;

endpackage

// ---- hdl/cfds_scheduler.sv ----
// Crosspoint field-delay scheduler: delay setting, tagging and field-timed delivery
`timescale 1ns/1ps
`include "cfds_defines.svh"
// Behaviour
// - Delay command carries decimal field count
// - Below minimum requests use the minimum
// - Above maximum requests use the maximum
// - Setting delay never stalls command flow
// - Each crosspoint buffered with target field tag
// - Target equals end field plus delay plus one
// - Delay includes hardware; zero gives minimum
// - Delay counted in whole fields only
// - Minimum delay is fixed per variant
// - Late crosspoints go out as soon as possible
// - One delay value for all ports
// - Changed delay stored and reloaded at power-up
// - Crosspoint state recorded on receipt immediately
module cfds_scheduler (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic field_mark,
  input wire logic delay_set_valid,
  input wire logic [7:0] delay_set_value,
  input wire logic xpt_in_valid,
  input wire cfds_pkg::cfds_xpt_t xpt_in,
  input wire logic string_end,
  input wire logic nv_rd_valid,
  input wire logic [7:0] nv_rd_data,
  output logic xpt_in_ready_r,
  output logic state_upd_valid_r,
  output cfds_pkg::cfds_xpt_t state_upd_r,
  output logic xpt_out_valid_r,
  output cfds_pkg::cfds_xpt_t xpt_out_r,
  output logic xpt_out_late_r,
  output cfds_pkg::cfds_field_t field_num_r,
  output logic [7:0] delay_r,
  output logic nv_wr_valid_r,
  output logic [7:0] nv_wr_data_r
);

  // ****************************************
  // Functions
  // ****************************************

  // Clamp a requested delay into the supported range
  function automatic logic [7:0] clamp_delay(input logic [7:0] req);
    logic [7:0] res;
    res = req;
    if (req < `CFDS_MIN_DELAY) begin
      res = `CFDS_MIN_DELAY;
    end else if (req > `CFDS_MAX_DELAY) begin
      res = `CFDS_MAX_DELAY;
    end
    return res;
  endfunction

  // Tag has been reached by the counter (wrap-safe)
  function automatic logic tag_due(input cfds_pkg::cfds_field_t tag,
                                   input cfds_pkg::cfds_field_t cnt);
    cfds_pkg::cfds_field_t diff;
    diff = cnt - tag;
    return ~diff[7];
  endfunction

  // Lowest set bit index of a slot vector
  function automatic logic [`CFDS_IDX_W-1:0] first_set(input logic [`CFDS_DEPTH-1:0] vec);
    logic [`CFDS_IDX_W-1:0] idx;
    idx = '0;
    for (int i = `CFDS_DEPTH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = i[`CFDS_IDX_W-1:0];
      end
    end
    return idx;
  endfunction

  // ****************************************
  // Field mark synchroniser
  // ****************************************

  logic fm_s1_r; // First stage, read only by second
  logic fm_s2_r; // Second stage
  logic fm_s3_r; // Third stage
  logic fm_lvl_r; // Accepted level
  logic fm_pulse; // One-cycle mark event

  // Three-flop chain on the field mark pin
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fm_s1_r <= 1'b0;
      fm_s2_r <= 1'b0;
      fm_s3_r <= 1'b0;
    end else begin
      fm_s1_r <= field_mark;
      fm_s2_r <= fm_s1_r;
      fm_s3_r <= fm_s2_r;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fm_lvl_r <= 1'b0;
    end else if (fm_s2_r == fm_s3_r) begin
      fm_lvl_r <= fm_s3_r;
    end
  end

  assign fm_pulse = (fm_s2_r == fm_s3_r) && fm_s3_r && !fm_lvl_r;

  // Field counter, one step per mark
  always_ff @(posedge core_clk) begin
    if (srst) begin
      field_num_r <= 8'h00;
    end else if (fm_pulse) begin
      field_num_r <= field_num_r + 8'h01;
    end
  end

  // ****************************************
  // Delay setting
  // ****************************************

  logic [7:0] eff_delay; // Delay seen by a string ending now

  // Same-cycle setting applies to the ending string
  assign eff_delay = delay_set_valid ? clamp_delay(delay_set_value) : delay_r;

  // Router-wide delay value, reloaded from storage at power-up
  always_ff @(posedge core_clk) begin
    if (srst) begin
      delay_r <= `CFDS_DELAY_RST;
    end else if (delay_set_valid) begin
      delay_r <= clamp_delay(delay_set_value);
    end else if (nv_rd_valid) begin
      delay_r <= clamp_delay(nv_rd_data);
    end
  end

  // Write a changed value to storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nv_wr_valid_r <= 1'b0;
      nv_wr_data_r <= 8'h00;
    end else begin
      nv_wr_valid_r <= delay_set_valid && (clamp_delay(delay_set_value) != delay_r);
      if (delay_set_valid) begin
        nv_wr_data_r <= clamp_delay(delay_set_value);
      end
    end
  end

  // ****************************************
  // State record
  // ****************************************

  // Report each accepted crosspoint at once
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_upd_valid_r <= 1'b0;
      state_upd_r <= '0;
    end else begin
      state_upd_valid_r <= xpt_in_valid && xpt_in_ready_r;
      if (xpt_in_valid && xpt_in_ready_r) begin
        state_upd_r <= xpt_in;
      end
    end
  end

  // ****************************************
  // Delivery buffer
  // ****************************************

  logic [`CFDS_DEPTH-1:0] ent_v_r; // Slot holds a crosspoint
  logic [`CFDS_DEPTH-1:0] ent_pend_r; // Slot awaits its string end
  cfds_pkg::cfds_field_t ent_tag_r [`CFDS_DEPTH]; // Target field per slot
  cfds_pkg::cfds_xpt_t ent_x_r [`CFDS_DEPTH]; // Connection per slot
  logic [`CFDS_DEPTH-1:0] due_vec; // Slots ready to go out
  logic [`CFDS_IDX_W-1:0] free_idx; // Slot for next insert
  logic [`CFDS_IDX_W-1:0] due_idx; // Slot for next delivery
  logic do_ins; // Insert this cycle
  logic do_out; // Deliver this cycle
  cfds_pkg::cfds_field_t end_tag; // Tag for a string ending now
  logic [`CFDS_IDX_W:0] free_cnt; // Count of empty slots

  // Due slots, and the count of free slots
  always_comb begin
    free_cnt = '0;
    for (int i = 0; i < `CFDS_DEPTH; i++) begin
      due_vec[i] = ent_v_r[i] && !ent_pend_r[i] && tag_due(ent_tag_r[i], field_num_r);
      free_cnt = free_cnt + {{`CFDS_IDX_W{1'b0}}, !ent_v_r[i]};
    end
  end

  assign free_idx = first_set(~ent_v_r);
  assign due_idx = first_set(due_vec);
  assign do_ins = xpt_in_valid && xpt_in_ready_r;
  assign do_out = |due_vec;
  assign end_tag = field_num_r + eff_delay + `CFDS_FIELD_ADD;

  // Slot flags: insert as pending, tag at string end, free on delivery
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ent_v_r <= '0;
      ent_pend_r <= '0;
    end else begin
      if (string_end) begin
        ent_pend_r <= '0;
      end
      if (do_out) begin
        ent_v_r[due_idx] <= 1'b0;
      end
      if (do_ins) begin
        ent_v_r[free_idx] <= 1'b1;
        ent_pend_r[free_idx] <= !string_end;
      end
    end
  end

  // Slot contents and target tags
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `CFDS_DEPTH; i++) begin
      if (string_end && ent_pend_r[i]) begin
        ent_tag_r[i] <= end_tag;
      end
    end
    if (do_ins) begin
      ent_x_r[free_idx] <= xpt_in;
      ent_tag_r[free_idx] <= end_tag;
    end
  end

  // Back-pressure toward the parser, one slot kept in hand
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xpt_in_ready_r <= 1'b0;
    end else begin
      xpt_in_ready_r <= free_cnt > 5'h02;
    end
  end

  // Hand one due crosspoint per cycle to the hardware
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xpt_out_valid_r <= 1'b0;
      xpt_out_r <= '0;
      xpt_out_late_r <= 1'b0;
    end else begin
      xpt_out_valid_r <= do_out;
      if (do_out) begin
        xpt_out_r <= ent_x_r[due_idx];
        xpt_out_late_r <= ent_tag_r[due_idx] != field_num_r;
      end
    end
  end

endmodule

// ---- test/cfds_host_model.sv ----
// Host model sending one-crosspoint command strings
`timescale 1ns/1ps
module cfds_host_model (
  input logic core_clk,
  input logic srst,
  input logic go,
  input cfds_pkg::cfds_xpt_t x,
  input logic xpt_in_ready_r,
  output logic xpt_in_valid = 1'b0,
  output cfds_pkg::cfds_xpt_t xpt_in = '0,
  output logic string_end = 1'b0
);
  // Crosspoint held until taken, then string closed
  always @(posedge core_clk) begin
    // String closes one cycle after its crosspoint is taken
    string_end <= !srst && xpt_in_valid && xpt_in_ready_r;
    if (srst) begin
      xpt_in_valid <= 1'b0;
    end else if (xpt_in_valid && xpt_in_ready_r) begin
      xpt_in_valid <= 1'b0;
      xpt_in <= ~xpt_in; // Released data turns over
    end else if (go) begin
      xpt_in_valid <= 1'b1;
      xpt_in <= x;
    end
  end
endmodule

// ---- test/cfds_scheduler_props.sv ----
// Port checker for the field-delay scheduler
`timescale 1ns/1ps
`include "cfds_defines.svh"
module cfds_scheduler_props (
  input logic core_clk,
  input logic srst,
  input logic field_mark,
  input logic delay_set_valid,
  input logic [7:0] delay_set_value,
  input logic xpt_in_valid,
  input cfds_pkg::cfds_xpt_t xpt_in,
  input logic xpt_in_ready_r,
  input logic state_upd_valid_r,
  input cfds_pkg::cfds_xpt_t state_upd_r,
  input cfds_pkg::cfds_field_t field_num_r,
  input logic [7:0] delay_r,
  input logic nv_wr_valid_r,
  input logic [7:0] nv_wr_data_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // Delay setting checks
  // ****************************************
  // Request class of a delay setting
  wire set_lo = delay_set_valid && delay_set_value < `CFDS_MIN_DELAY;
  wire set_hi = delay_set_valid && delay_set_value > `CFDS_MAX_DELAY;
  property p_lo; set_lo |=> delay_r == `CFDS_MIN_DELAY; endproperty
  a_lo: assert property (p_lo) else $error("low delay not raised");
  property p_hi; set_hi |=> delay_r == `CFDS_MAX_DELAY; endproperty
  a_hi: assert property (p_hi) else $error("high delay not cut");
  property p_in; delay_set_valid && !set_lo && !set_hi |=> delay_r == $past(delay_set_value);
  endproperty
  a_in: assert property (p_in) else $error("delay not taken");
  property p_nv; nv_wr_valid_r |-> nv_wr_data_r == delay_r && delay_r != $past(delay_r);
  endproperty
  a_nv: assert property (p_nv) else $error("bad store");
  property p_rng; delay_r >= `CFDS_MIN_DELAY && delay_r <= `CFDS_MAX_DELAY; endproperty
  a_rng: assert property (p_rng) else $error("delay out of range");
  // ****************************************
  // State record and field counter checks
  // ****************************************
  // Taken crosspoint reported on the next cycle
  property p_st;
    xpt_in_valid && xpt_in_ready_r |=> state_upd_valid_r && state_upd_r == $past(xpt_in);
  endproperty
  a_st: assert property (p_st) else $error("state not recorded");
  property p_cnt; $changed(field_num_r) |-> field_num_r == $past(field_num_r) + 8'h01; endproperty
  a_cnt: assert property (p_cnt) else $error("field count jump");
  property p_mark; $rose(field_mark) |-> ##[2:6] $changed(field_num_r); endproperty
  a_mark: assert property (p_mark) else $error("mark not counted");
  // ****************************************
  // Main scenarios reached
  // ****************************************
  c_hi: cover property (set_hi);
  c_nv: cover property (nv_wr_valid_r);
  c_st: cover property (state_upd_valid_r);
endmodule
bind cfds_scheduler cfds_scheduler_props u_cfds_scheduler_props (.*);

// ---- test/tb_cfds_scheduler.sv ----
// Self-checking bench for the field-delay scheduler
`timescale 1ns/1ps
`include "cfds_defines.svh"
module tb_cfds_scheduler;
  logic core_clk = 0, srst = 1, field_mark = 0, go = 0, delay_set_valid = 0, nv_rd_valid = 0;
  logic xpt_in_valid, string_end, xpt_in_ready_r, state_upd_valid_r, xpt_out_valid_r;
  logic xpt_out_late_r, nv_wr_valid_r;
  logic [7:0] delay_set_value = 0, nv_rd_data = 0, tag, delay_r, nv_wr_data_r;
  logic [7:0] corner [7] = '{8'h00, 8'h01, 8'h02, 8'h3C, 8'h3D, 8'hFF, 8'h00};
  logic [31:0] seed = 32'h299DD985, num_errors = 0, cmp_count = 0;
  cfds_pkg::cfds_xpt_t x = '0, xpt_in, state_upd_r, xpt_out_r;
  cfds_pkg::cfds_field_t field_num_r;
  // ****************************************
  // Clock, field marks and instances
  // ****************************************
  always #10 core_clk = ~core_clk;
  // Field marks every 40 cycles
  always begin
    repeat (30) @(posedge core_clk);
    field_mark <= 1'b1;
    repeat (10) @(posedge core_clk);
    field_mark <= 1'b0;
  end
  cfds_scheduler u_cfds_scheduler (.*);
  cfds_host_model u_cfds_host_model (.*);
  // ****************************************
  // Helpers and checking
  // ****************************************
  // Random source for stimulus
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] clamp(input logic [7:0] v);
    return v < `CFDS_MIN_DELAY ? `CFDS_MIN_DELAY : (v > `CFDS_MAX_DELAY ? `CFDS_MAX_DELAY : v);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bound ran out
  task automatic guard(input int k, input int n);
    if (k >= n) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic set_delay(input logic [7:0] v);
    logic [7:0] old;
    @(posedge core_clk);
    old = delay_r;
    delay_set_valid <= 1'b1;
    delay_set_value <= v;
    @(posedge core_clk);
    delay_set_valid <= 1'b0;
    #1;
    check(delay_r, clamp(v));
    check(nv_wr_valid_r, clamp(v) != old);
  endtask
  // One string; delay set before it or on its end
  task automatic send(input logic [7:0] d, input logic same);
    int k;
    // Delay settled first and left alone while the string is in flight
    if (!same) set_delay(d);
    seed = lfsr(seed);
    x = seed[21:0];
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    for (k = 0; k < 20 && !(xpt_in_valid && xpt_in_ready_r); k++) @(posedge core_clk);
    guard(k, 20);
    delay_set_valid <= same;
    delay_set_value <= d;
    @(posedge core_clk);
    delay_set_valid <= 1'b0;
    // Target field: counter at this string end plus delay plus one
    tag = field_num_r + clamp(d) + 8'h01;
    #1;
    // Recorded at once, long before the hardware sees it
    check(state_upd_r, x);
    check(xpt_out_valid_r, 1'b0);
    for (k = 0; k < 3000 && xpt_out_valid_r !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    guard(k, 3000);
    check(field_num_r, tag);
    check(xpt_out_r, x);
    check(xpt_out_late_r, 1'b0);
    check(state_upd_r, x);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nv_rd_valid <= 1'b1;
    nv_rd_data <= 8'h07;
    @(posedge core_clk);
    nv_rd_valid <= 1'b0;
    #1;
    check(delay_r, 8'h07);
    foreach (corner[i]) set_delay(corner[i]);
    repeat (6) begin
      seed = lfsr(seed);
      set_delay(seed[7:0]);
    end
    send(8'hFF, 1'b1);
    send(8'h00, 1'b0);
    repeat (6) begin
      seed = lfsr(seed);
      send({4'h0, seed[3:0]}, seed[4]);
    end
    report_and_stop();
  end
endmodule
